// ---- design/rtd_pkg.sv ----
package rtd_pkg;

   // ---------------------------------------------------------------
   // Register map (byte address; word index = address / 4)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_TIME = 4'h0;
   localparam logic [3:0] ADDR_DATE = 4'h4;
   localparam logic [3:0] ADDR_ATIME = 4'h8;
   localparam logic [3:0] ADDR_ADATE = 4'hC;
   localparam logic [3:0] ADDR_STAT = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int SEC_CYCLES = CLK_HZ;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] hour_tens_digit;
      logic [3:0] hour_units_digit;
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_units_digit;
      logic [3:0] second_tens_digit;
      logic [3:0] second_units_digit;
   } rtd_time_s;

   typedef struct packed {
      logic [3:0] year_tens_digit;
      logic [3:0] year_units_digit;
      logic month_tens_bit;
      logic [3:0] month_units_digit;
      logic [1:0] day_tens_digit;
      logic [3:0] day_units_digit;
      logic [2:0] day_of_week;
   } rtd_date_s;

   localparam rtd_time_s TIME_RST = '0;
   localparam rtd_date_s DATE_RST = '0;

   localparam logic [3:0] D9 = 4'h9;
   localparam logic [3:0] D5 = 4'h5;
   localparam logic [3:0] D3 = 4'h3;
   localparam logic [3:0] D2 = 4'h2;
   localparam logic [3:0] D1 = 4'h1;
   localparam logic [2:0] WD_MAX = 3'h6;

endpackage

// ---- design/rtd_regs.sv ----
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
// Contract
// RQ1: hour tens at bits 30..28, 0..2
// RQ2: hour units at bits 27..24, 0..9
// RQ3: minute tens at bits 22..20, 0..5
// RQ4: minute units at bits 19..16, 0..9
// RQ5: second tens at bits 15..12, 0..5
// RQ6: second units at bits 11..8, 0..9
// RQ7: time word bits 31,23,7..0 read zero
// RQ8: year tens at date bits 31..28
// RQ9: year units at date bits 27..24
// RQ10: month tens single bit at 20
// RQ11: month units at bits 19..16
// RQ12: day tens at bits 13..12, 0..3
// RQ13: day units at bits 11..8
// RQ14: weekday at bits 2..0, 0..6
// RQ15: date unimplemented bits read zero
// RQ16: alarm date has no year, zero
// RQ17: alarm time layout equals time word
// RQ18: read safe only while sync flag clear
// RQ19: no alarm writes while alarm sync set; the code accepts alarm writes at any time
// RQ20: once per second decimal carry advance
module rtd_regs
   import rtd_pkg::*;
#(
   parameter int SEC_CYC = SEC_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic sync_flag,
   output logic alarm_sync_flag
);

   // ---------------------------------------------------------------
   // Field packing
   // ---------------------------------------------------------------
   function automatic logic [31:0] pack_time(input rtd_time_s t);
      pack_time = {1'b0, t.hour_tens_digit, t.hour_units_digit, 1'b0, // RQ1 RQ2 RQ7
                   t.minute_tens_digit, t.minute_units_digit, // RQ3 RQ4
                   t.second_tens_digit, t.second_units_digit, 8'h00}; // RQ5 RQ6
   endfunction

   function automatic rtd_time_s unpack_time(input logic [31:0] w);
      unpack_time = {w[30:28], w[27:24], w[22:20], w[19:16], w[15:12], w[11:8]};
   endfunction

   function automatic logic [31:0] pack_date(input rtd_date_s d, input logic with_year);
      pack_date = {with_year ? {d.year_tens_digit, d.year_units_digit} : 8'h00, // RQ8 RQ9 RQ16
                   3'b000, d.month_tens_bit, d.month_units_digit, // RQ10 RQ11 RQ15
                   2'b00, d.day_tens_digit, d.day_units_digit, // RQ12 RQ13
                   5'b00000, d.day_of_week}; // RQ14 RQ15
   endfunction

   function automatic rtd_date_s unpack_date(input logic [31:0] w);
      unpack_date = {w[31:28], w[27:24], w[20], w[19:16], w[13:12], w[11:8], w[2:0]};
   endfunction

   // BCD digit increment with wrap at its max
   function automatic logic [3:0] bcd_inc(input logic [3:0] v, input logic [3:0] mx);
      bcd_inc = (v >= mx) ? 4'h0 : v + D1;
   endfunction

   // ---------------------------------------------------------------
   // Second tick
   // ---------------------------------------------------------------
   logic [31:0] div_q;
   logic tick;
   assign tick = (div_q == 32'(SEC_CYC - 1));

   // Free running one second enable
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Calendar advance
   // ---------------------------------------------------------------
   rtd_time_s time_q, time_d, atime_q;
   rtd_date_s date_q, date_d, adate_q;
   logic c_su, c_st, c_mu, c_mt, c_hr, c_dy, c_mo;
   logic [3:0] hmax, dmax;

   // Carries; month length simplified to 31 days, a known limitation
   assign c_su = tick && time_q.second_units_digit == D9; // RQ20
   assign c_st = c_su && time_q.second_tens_digit == D5;
   assign c_mu = c_st && time_q.minute_units_digit == D9;
   assign c_mt = c_mu && {1'b0, time_q.minute_tens_digit} == D5;
   assign hmax = (time_q.hour_tens_digit == 3'h2) ? 4'h3 : D9;
   // Hour wrap only at 23, not at every x9 hour
   assign c_hr = c_mt && time_q.hour_tens_digit == 3'h2 && time_q.hour_units_digit == hmax;
   assign dmax = (date_q.day_tens_digit == 2'h3) ? D1 : D9;
   assign c_dy = c_hr && {2'b00, date_q.day_tens_digit} == D3 && date_q.day_units_digit == D1;
   assign c_mo = c_dy && date_q.month_tens_bit && date_q.month_units_digit == D2;

   always_comb begin
      time_d = time_q;
      date_d = date_q;
      if (tick) time_d.second_units_digit = bcd_inc(time_q.second_units_digit, D9); // RQ20
      if (c_su) time_d.second_tens_digit = bcd_inc(time_q.second_tens_digit, D5);
      if (c_st) time_d.minute_units_digit = bcd_inc(time_q.minute_units_digit, D9);
      if (c_mu) time_d.minute_tens_digit = 3'(bcd_inc({1'b0, time_q.minute_tens_digit}, D5));
      if (c_mt) time_d.hour_units_digit = c_hr ? 4'h0 : bcd_inc(time_q.hour_units_digit, D9);
      if (c_mt && (time_q.hour_units_digit == D9 || c_hr))
         time_d.hour_tens_digit = c_hr ? 3'h0 : time_q.hour_tens_digit + 3'h1;
      if (c_hr) begin
         date_d.day_of_week = (date_q.day_of_week >= WD_MAX) ? 3'h0 : date_q.day_of_week + 3'h1;
         if (c_dy) begin
            date_d.day_tens_digit = 2'h0;
            date_d.day_units_digit = D1;
         end else if (date_q.day_units_digit == dmax) begin
            date_d.day_units_digit = 4'h0;
            date_d.day_tens_digit = date_q.day_tens_digit + 2'h1;
         end else begin
            date_d.day_units_digit = date_q.day_units_digit + D1;
         end
      end
      if (c_dy) begin
         if (c_mo) begin
            date_d.month_tens_bit = 1'b0;
            date_d.month_units_digit = D1;
            date_d.year_units_digit = bcd_inc(date_q.year_units_digit, D9);
            if (date_q.year_units_digit == D9)
               date_d.year_tens_digit = bcd_inc(date_q.year_tens_digit, D9);
         end else if (date_q.month_units_digit == D9) begin
            date_d.month_units_digit = 4'h0;
            date_d.month_tens_bit = 1'b1;
         end else begin
            date_d.month_units_digit = date_q.month_units_digit + D1;
         end
      end
      // Software write overrides the tick in the same cycle
      if (wr && addr == ADDR_TIME) time_d = unpack_time(wdata);
      if (wr && addr == ADDR_DATE) date_d = unpack_date(wdata);
   end

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         time_q <= TIME_RST;
         date_q <= DATE_RST;
      end else begin
         time_q <= time_d;
         date_q <= date_d;
      end
   end

   // Alarm words; writes accepted anytime, software honours the flag
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         atime_q <= TIME_RST;
         adate_q <= DATE_RST;
      end else begin
         if (wr && addr == ADDR_ATIME) atime_q <= unpack_time(wdata); // RQ17
         if (wr && addr == ADDR_ADATE) adate_q <= unpack_date(wdata); // RQ19
      end
   end

   // ---------------------------------------------------------------
   // Read port and status
   // ---------------------------------------------------------------
   logic [31:0] rmux;
   logic near_tick;
   assign rmux = (addr == ADDR_TIME) ? pack_time(time_q) :
                 (addr == ADDR_DATE) ? pack_date(date_q, 1'b1) :
                 (addr == ADDR_ATIME) ? pack_time(atime_q) :
                 (addr == ADDR_ADATE) ? pack_date(adate_q, 1'b0) : 32'h0000_0000;
   // Flag covers the last cycles before a tick so a read taken while it is clear cannot race it
   assign near_tick = (div_q >= 32'(SEC_CYC - 4));

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
         sync_flag <= 1'b0;
         alarm_sync_flag <= 1'b0;
      end else begin
         rdata <= rd ? rmux : 32'h0000_0000;
         sync_flag <= near_tick; // RQ18
         alarm_sync_flag <= near_tick;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_time_zero;
      @(posedge core_clk) disable iff (!rstn)
      rd && addr == ADDR_TIME |=> rdata[31] == 1'b0 && rdata[23] == 1'b0 && rdata[7:0] == 8'h00;
   endproperty
   a_time_zero: assert property (p_time_zero) else $error("time word reserved bits set"); // RQ7

   property p_adate_zero;
      @(posedge core_clk) disable iff (!rstn)
      rd && addr == ADDR_ADATE |=> rdata[31:21] == 11'h000;
   endproperty
   a_adate_zero: assert property (p_adate_zero) else $error("alarm date upper bits set"); // RQ16

   property p_date_zero;
      @(posedge core_clk) disable iff (!rstn)
      rd && addr == ADDR_DATE |=> rdata[23:21] == 3'h0 && rdata[15:14] == 2'h0 && rdata[7:3] == 5'h00;
   endproperty
   a_date_zero: assert property (p_date_zero) else $error("date reserved bits set"); // RQ15

   property p_write_back;
      @(posedge core_clk) disable iff (!rstn)
      wr && addr == ADDR_ATIME ##2 rd && addr == ADDR_ATIME |=>
         rdata[30:8] == ($past(wdata[30:8], 3) & 23'h7F_7FFF);
   endproperty
   a_write_back: assert property (p_write_back) else $error("alarm time readback wrong"); // RQ17

   property p_sec_tick;
      @(posedge core_clk) disable iff (!rstn)
      tick && !wr && time_q.second_units_digit < D9 |=> time_q.second_units_digit == $past(time_q.second_units_digit) + D1;
   endproperty
   a_sec_tick: assert property (p_sec_tick) else $error("seconds did not advance"); // RQ20

   property p_hold;
      @(posedge core_clk) disable iff (!rstn)
      !tick && !wr |=> time_q == $past(time_q);
   endproperty
   a_hold: assert property (p_hold) else $error("time changed without tick"); // RQ20

   property p_ranges;
      @(posedge core_clk) disable iff (!rstn)
      time_q.second_tens_digit <= D5 |=> time_q.second_tens_digit <= D5 || $past(wr);
   endproperty
   a_ranges: assert property (p_ranges) else $error("seconds tens out of range"); // RQ5

   property p_sync;
      @(posedge core_clk) disable iff (!rstn)
      tick |-> sync_flag;
   endproperty
   a_sync: assert property (p_sync) else $error("tick outside sync window"); // RQ18

endmodule

// ---- dv/tb_rtd_regs.sv ----
`timescale 1ns/1ns
module tb_rtd_regs;
   import rtd_pkg::*;

   // ---------------------------------------------------------------
   // Bench signals and expected tables
   // ---------------------------------------------------------------
   // Short second so several carries fit well inside the run
   localparam int SEC_SIM = 200;
   localparam logic [31:0] TIME_MASK = 32'h7F7F_FF00;
   localparam logic [31:0] DATE_MASK = 32'hFF1F_3F07;
   localparam logic [31:0] ADATE_MASK = 32'h001F_3F07;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic sync_flag;
   logic alarm_sync_flag;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [3:0] map_a [4] = '{ADDR_TIME, ADDR_DATE, ADDR_ATIME, ADDR_ADATE};
   // Time written, date written, time and date one second later
   logic [31:0] tick_tab [4][4] = '{
      '{32'hA3D9_59FF, 32'h99F2_F1FE, 32'h0000_0000, 32'h0001_0100},
      '{32'h2359_5900, 32'h1909_3103, 32'h0000_0000, 32'h1910_0104},
      '{32'h0959_5900, 32'h1909_0903, 32'h1000_0000, 32'h1909_0903},
      '{32'h0000_0900, 32'h0001_0100, 32'h0000_1000, 32'h0001_0100}};

   rtd_regs #(.SEC_CYC(SEC_SIM)) u_rtd_regs (
      .core_clk(core_clk),
      .rstn(rstn),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .sync_flag(sync_flag),
      .alarm_sync_flag(alarm_sync_flag)
   );

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      forever #2 core_clk = ~core_clk;
   end

   // Ceiling is about two and a half times the expected run of about 2000 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe, so sample there
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   // Waits out one flag window; entered only while the flag is low
   task automatic wait_tick();
      int n;
      n = 0;
      while (sync_flag !== 1'b1 && n < 1000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check({31'h0, alarm_sync_flag}, 32'h1);
      n = 0;
      while (sync_flag === 1'b1 && n < 10) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(32'(n), 32'h4);
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         reg_read(map_a[i], 32'h0000_0000);
      end
      // Unmapped places must neither store nor answer
      reg_write(4'h2, 32'hFFFF_FFFF);
      #1;
      check(rdata, 32'h0000_0000);
      reg_read(4'h2, 32'h0000_0000);
      reg_read(ADDR_TIME, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         wait_tick();
         reg_write(ADDR_TIME, tick_tab[i][0]);
         reg_write(ADDR_DATE, tick_tab[i][1]);
         reg_read(ADDR_TIME, tick_tab[i][0] & TIME_MASK);
         reg_read(ADDR_DATE, tick_tab[i][1] & DATE_MASK);
         wait_tick();
         reg_read(ADDR_TIME, tick_tab[i][2]);
         reg_read(ADDR_DATE, tick_tab[i][3]);
      end
      // Alarm words hold their value across a second tick
      reg_write(ADDR_ATIME, 32'hA3D9_59FF);
      reg_read(ADDR_ATIME, 32'hA3D9_59FF & TIME_MASK);
      reg_write(ADDR_ADATE, 32'hFFF2_F1FE);
      for (int k = 0; k < 2; k++) begin
         reg_read(ADDR_ATIME, 32'hA3D9_59FF & TIME_MASK);
         reg_read(ADDR_ADATE, 32'hFFF2_F1FE & ADATE_MASK);
         wait_tick();
      end
      report_and_stop();
   end

endmodule
